// *** hw/isc_capture.sv ***
`timescale 1ns/10ps
`default_nettype none
// per-source live/sticky capture bank
module isc_capture #(
    parameter int N = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // source bundle
    isc_src_if.cap   src
);
    logic [N-1:0] prev_reg;   // last condition, for edge detection
    logic [N-1:0] latch_reg;  // sticky latches
    logic [N-1:0] latch_next;
    logic [N-1:0] rise;

    assign rise = src.cond & ~prev_reg;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_src
            // set wins over a clear in the same cycle
            assign latch_next[i] = !src.sticky[i] ? 1'b0 :
                rise[i] ? 1'b1 :
                src.clear[i] ? 1'b0 : latch_reg[i];
            // live mode shows the source directly
            assign src.flag[i] = src.sticky[i] ? latch_reg[i]
                                               : src.cond[i];
        end
    endgenerate

    // any latched bit holds the request
    assign src.any_held = |latch_reg;

    // edge history and latches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg  <= '0;
            latch_reg <= '0;
        end else begin
            prev_reg  <= src.cond;
            latch_reg <= latch_next;
        end
    end
endmodule
`default_nettype wire

// *** hw/isc_consts.svh ***
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// register indices: each register is one word at four times its index
`define ISC_OFF_PLL_LANE     12'h023
`define ISC_OFF_PATTERN      12'h024
`define ISC_OFF_PAIR_A       12'h025
`define ISC_OFF_STICKY_SEL   12'h010
`define ISC_OFF_LINK_CTRL    12'h011
`define ISC_OFF_LANE_FULL    12'h30c
`define ISC_OFF_LANE_EMPTY   12'h30d

// field positions in the first status register
`define ISC_BIT_PLL_LOCK     2
`define ISC_BIT_LANE_ERR     1
// field positions in the third status register
`define ISC_BIT_POWER_ERR    7
`define ISC_BIT_BLANK_DONE   5
`define ISC_BIT_OSC_ALIGN    4

// reset values
`define ISC_RST_FLAGS        8'h00
`define ISC_RST_STICKY       8'h00
`define ISC_RST_LINK_CTRL    8'h01

// live-bit masks: reserved bits read zero
`define ISC_MASK_PLL_LANE    8'h06
`define ISC_MASK_PATTERN     8'h0f
`define ISC_MASK_PAIR_A      8'hb0

// number of capture sources
`define ISC_NUM_SRC          9

`endif

// *** hw/isc_pkg.sv ***
package isc_pkg;
    // axi-lite response codes
    typedef enum logic [1:0] {
        ISC_RESP_OKAY   = 2'b00,
        ISC_RESP_SLVERR = 2'b10
    } isc_resp_e;
    // one flag byte
    typedef logic [7:0] isc_byte_t;
endpackage

// *** hw/isc_src_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// bundle between the top and the capture cells
interface isc_src_if #(parameter int N = 9);
    logic [N-1:0] cond;     // synchronised source levels
    logic [N-1:0] sticky;   // per-source mode select
    logic [N-1:0] clear;    // write-one-to-clear strobes
    logic [N-1:0] flag;     // reported bit
    logic         any_held; // some latched bit set
    modport ctrl (output cond, sticky, clear, input flag, any_held);
    modport cap  (input cond, sticky, clear, output flag, any_held);
endinterface
`default_nettype wire

// *** hw/isc_top.sv ***
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "isc_consts.svh"

// Contract
// - live mode: bit follows source
// - sticky mode: rising edge latches bit
// - latched bit pulls interrupt low
// - write one clears only those bits
// - pll lock at bit 2, reset 0
// - lane error on any full/empty
// - lane error holds until link re-enabled
// - full and empty lanes readable separately
// - pattern fail channels at bits 3..0
// - pattern register bits 7..4 read zero
// - bit 7: pair a power error
// - bit 5 blanking done, 6 zero
// - bit 4: oscillator align trip
module isc_top #(
    parameter int LANES = 8
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // axi4-lite write address
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output var  logic                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output var  logic                     s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]               s_axi_bresp,
    output var  logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output var  logic                     s_axi_arready,
    // axi4-lite read data
    output var  logic [31:0]              s_axi_rdata,
    output var  logic [1:0]               s_axi_rresp,
    output var  logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // asynchronous status sources
    input  wire logic                     link_pll_locked,
    input  wire logic [LANES-1:0]         lane_full,
    input  wire logic [LANES-1:0]         lane_empty,
    input  wire logic [3:0]               pattern_fail,
    input  wire logic                     power_threshold_error_pair_a,
    input  wire logic                     blanking_complete_pair_a,
    input  wire logic                     oscillator_align_trip_pair_a,
    // link enable to the deserialiser path
    output var  logic                     link_enable,
    // interrupt request, active low
    output var  logic                     irq_n
);
    import isc_pkg::*;

    localparam int N = `ISC_NUM_SRC;
    localparam int SW = 2 * LANES + 8; // sync width: full and empty lanes plus 8 pins

    // source order in the capture bank
    // 0 pll lock, 1 lane err, 2..5 pattern ch0..3,
    // 6 osc align, 7 blanking, 8 power error
    isc_src_if #(.N(N)) src ();

    // two-stage synchroniser for all pins
    logic [SW-1:0] sync1_reg;  // first stage, read by stage two only
    logic [SW-1:0] sync2_reg;  // safe to use
    logic [SW-1:0] raw_in;
    assign raw_in = {lane_full, lane_empty, power_threshold_error_pair_a,
                     blanking_complete_pair_a, oscillator_align_trip_pair_a,
                     pattern_fail, link_pll_locked};

    // synchroniser stages
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // named synchronised views
    logic [LANES-1:0] full_s;
    logic [LANES-1:0] empty_s;
    assign full_s  = sync2_reg[SW-1 -: LANES];
    assign empty_s = sync2_reg[LANES+7 : 8];

    // software registers
    logic [N-1:0] sticky_reg;     // per-source mode select
    logic         link_en_reg;    // link enable control
    logic         link_en_d_reg;  // previous enable, for re-enable edge
    logic         lane_err_reg;   // persistent lane buffer error
    logic         lane_err_next;

    // lane error: set on any full/empty, removed by link re-enable
    logic lane_hit;
    logic relink;
    assign lane_hit = |full_s | |empty_s;
    assign relink   = link_en_reg & ~link_en_d_reg;
    // a fresh hit wins over a re-enable in the same cycle
    assign lane_err_next = lane_hit ? 1'b1 :
                           relink   ? 1'b0 : lane_err_reg;

    // hand conditions to the capture bank
    // pin order in sync2: 0 pll, 4..1 pattern, 5 osc, 6 blank, 7 power
    assign src.cond = {sync2_reg[7], sync2_reg[6], sync2_reg[5],
                       sync2_reg[4:1], lane_err_reg, sync2_reg[0]};
    assign src.sticky = sticky_reg;

    isc_capture #(.N(N)) u_cap (
        .clk    (clk),
        .arst_n (arst_n),
        .src    (src)
    );

    // address decode helper: o is a register index, one word per index
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[9:0]);
    endfunction

    // any mapped register, for the response code of either channel
    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `ISC_OFF_PLL_LANE) | hit(a, `ISC_OFF_PATTERN)
               | hit(a, `ISC_OFF_PAIR_A) | hit(a, `ISC_OFF_STICKY_SEL)
               | hit(a, `ISC_OFF_LINK_CTRL) | hit(a, `ISC_OFF_LANE_FULL)
               | hit(a, `ISC_OFF_LANE_EMPTY);
    endfunction

    // --- write channel: accept address and data in either order ---
    logic        aw_have_reg;   // address captured
    logic        w_have_reg;    // data captured
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_fire;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    assign wa = aw_addr_reg;
    assign wd = w_data_reg;
    assign ws = w_strb_reg;

    // every register is one aligned word; flags sit in its low byte
    logic [7:0] wbyte;     // low data byte
    logic       wlane_on;  // low byte strobed
    assign wbyte    = wd[7:0];
    assign wlane_on = ws[0];

    logic wr_flags0;
    logic wr_flags1;
    logic wr_flags2;
    logic wr_sticky;
    logic wr_ctrl;
    logic wr_known;
    assign wr_flags0 = wr_fire & wlane_on & hit(wa, `ISC_OFF_PLL_LANE);
    assign wr_flags1 = wr_fire & wlane_on & hit(wa, `ISC_OFF_PATTERN);
    assign wr_flags2 = wr_fire & wlane_on & hit(wa, `ISC_OFF_PAIR_A);
    assign wr_sticky = wr_fire & hit(wa, `ISC_OFF_STICKY_SEL) & ws[0] & ws[1];
    assign wr_ctrl   = wr_fire & hit(wa, `ISC_OFF_LINK_CTRL) & ws[0];
    assign wr_known  = mapped(wa);

    // write-one-to-clear strobes mapped to sources
    assign src.clear = {
        wr_flags2 & wbyte[`ISC_BIT_POWER_ERR],
        wr_flags2 & wbyte[`ISC_BIT_BLANK_DONE],
        wr_flags2 & wbyte[`ISC_BIT_OSC_ALIGN],
        {4{wr_flags1}} & wbyte[3:0],
        wr_flags0 & wbyte[`ISC_BIT_LANE_ERR],
        wr_flags0 & wbyte[`ISC_BIT_PLL_LOCK]};

    // status bytes as read
    isc_byte_t st0;
    isc_byte_t st1;
    isc_byte_t st2;
    assign st0 = {5'h00, src.flag[0], src.flag[1], 1'b0};
    assign st1 = {4'h0, src.flag[5:2]};
    assign st2 = {src.flag[8], 1'b0, src.flag[7],
                  src.flag[6], 4'h0};

    // read decode: one register per word, flags in the low byte
    logic [11:0] ra;
    logic [31:0] rd_word;
    logic        rd_known;
    logic [31:0] full_word;   // lane full view, zero-extended
    logic [31:0] empty_word;  // lane empty view, zero-extended
    assign ra = s_axi_araddr;
    assign full_word  = 32'(full_s);
    assign empty_word = 32'(empty_s);
    assign rd_known = mapped(ra);
    assign rd_word =
        hit(ra, `ISC_OFF_PLL_LANE)   ? {24'h000000, st0} :
        hit(ra, `ISC_OFF_PATTERN)    ? {24'h000000, st1} :
        hit(ra, `ISC_OFF_PAIR_A)     ? {24'h000000, st2} :
        hit(ra, `ISC_OFF_STICKY_SEL) ? {23'h000000, sticky_reg} :
        hit(ra, `ISC_OFF_LINK_CTRL)  ? {31'h00000000, link_en_reg} :
        hit(ra, `ISC_OFF_LANE_FULL)  ? full_word :
        hit(ra, `ISC_OFF_LANE_EMPTY) ? empty_word
                                     : 32'h00000000;

    // write address/data capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // ready flags and write response
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ISC_RESP_OKAY;
        end else begin
            // one write at a time: ready only while its own channel holds nothing and no response is pending
            s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready)
                           & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready)
                           & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? ISC_RESP_OKAY : ISC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= ISC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_known ? ISC_RESP_OKAY : ISC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control registers and lane error
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sticky_reg    <= '0;
            link_en_reg   <= 1'b1;
            link_en_d_reg <= 1'b1;
            lane_err_reg  <= 1'b0;
        end else begin
            if (wr_sticky) begin
                sticky_reg <= wd[N-1:0];
            end
            if (wr_ctrl) begin
                link_en_reg <= wd[0];
            end
            link_en_d_reg <= link_en_reg;
            lane_err_reg  <= lane_err_next;
        end
    end

    // registered pin outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n       <= 1'b1;
            link_enable <= 1'b1;
        end else begin
            irq_n       <= ~src.any_held;
            link_enable <= link_en_reg;
        end
    end
endmodule
`default_nettype wire

// *** tb/isc_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// port-level watcher for status reads and the interrupt line
module isc_checker #(
    parameter int LANES = 8
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             arst_n,
    // bus handshakes and read data
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [11:0]      s_axi_araddr,
    input wire logic             s_axi_rvalid,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    // sources and outputs
    input wire logic             link_pll_locked,
    input wire logic [LANES-1:0] lane_full,
    input wire logic [LANES-1:0] lane_empty,
    input wire logic [3:0]       pattern_fail,
    input wire logic             power_threshold_error_pair_a,
    input wire logic             blanking_complete_pair_a,
    input wire logic             oscillator_align_trip_pair_a,
    input wire logic             link_enable,
    input wire logic             irq_n
);
    logic [11:0]        ra;     // last read address taken
    logic [3:0]         wr_age; // cycles since a write address
    logic [3:0]         lstab;  // cycles lane pins unchanged
    logic [2*LANES-1:0] lp;     // lane pins one cycle ago
    wire src_any = link_pll_locked | (|pattern_fail) | (|lane_full)
        | (|lane_empty) | power_threshold_error_pair_a
        | blanking_complete_pair_a | oscillator_align_trip_pair_a;
    // one word per register: index is the byte address over four
    wire rd_pll  = s_axi_rvalid && ra[11:2] == 10'h023;
    wire rd_pat  = s_axi_rvalid && ra[11:2] == 10'h024;
    wire rd_pair = s_axi_rvalid && ra[11:2] == 10'h025;
    wire rd_lane = s_axi_rvalid && ra[11:3] == 9'h186; // full, then empty
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // counters saturate so a long idle never wraps into a false pass
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ra <= 12'h000;
            wr_age <= 4'hf;
            lstab <= 4'h0;
            lp <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready) wr_age <= 4'h0;
            else if (wr_age != 4'hf) wr_age <= wr_age + 4'h1;
            lp <= {lane_empty, lane_full};
            if (lp != {lane_empty, lane_full}) lstab <= 4'h0;
            else if (lstab != 4'hf) lstab <= lstab + 4'h1;
        end
    end
    property p_irq_fall;
        $fell(irq_n) |-> $past(src_any, 4);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell with no source raised");
    property p_irq_rise;
        $rose(irq_n) |-> wr_age < 4'h8;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt released without a write");
    property p_link_off;
        $fell(link_enable) |-> wr_age < 4'h8;
    endproperty
    a_link_off: assert property (p_link_off)
        else $error("link dropped without a write");
    property p_rsvd_pll;
        rd_pll |-> s_axi_rdata[31:3] == 29'h0 && !s_axi_rdata[0];
    endproperty
    a_rsvd_pll: assert property (p_rsvd_pll)
        else $error("reserved pll byte bits set");
    property p_rsvd_pat;
        rd_pat |-> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_rsvd_pat: assert property (p_rsvd_pat)
        else $error("reserved pattern bits set");
    property p_rsvd_pair;
        rd_pair |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[6]
            && s_axi_rdata[3:0] == 4'h0;
    endproperty
    a_rsvd_pair: assert property (p_rsvd_pair)
        else $error("reserved pair bits set");
    property p_rd_okay;
        (rd_pll || rd_pat || rd_pair) |-> s_axi_rresp == 2'b00;
    endproperty
    a_rd_okay: assert property (p_rd_okay)
        else $error("status read refused");
    property p_lane_live;
        rd_lane && lstab > 4'h5 |-> s_axi_rdata == (ra[2]
            ? 32'(lp[2*LANES-1:LANES]) : 32'(lp[LANES-1:0]));
    endproperty
    a_lane_live: assert property (p_lane_live)
        else $error("lane word differs from pins");
    c_irq_fall: cover property ($fell(irq_n));
    c_irq_rise: cover property ($rose(irq_n));
    c_lane_rd: cover property (rd_lane);
endmodule
bind isc_top isc_checker #(.LANES(LANES)) u_isc_chk (.*);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import isc_pkg::*;
    localparam int POS [9] = '{10, 9, 16, 17, 18, 19, 28, 29, 31};
    localparam int IX_STAT = 'h023; // first status register index
    localparam int IX_LANE = 'h30c; // lane full register index
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, link_enable, irq_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    logic [31:0] s_axi_rdata, rd_d;
    logic        link_pll_locked = 1'b0, power_threshold_error_pair_a = 1'b0;
    logic        blanking_complete_pair_a = 1'b0;
    logic        oscillator_align_trip_pair_a = 1'b0;
    logic [3:0]  pattern_fail = 4'h0;
    logic [7:0]  lane_full = 8'h00, lane_empty = 8'h00;
    logic [31:0] seed = 32'h00008395;
    int          n_fail = 0, comparisons = 0;
    int          c = 0, st = 0, lt = 0, lerr = 0; // model masks
    isc_top #(.LANES(8)) DUT (.*);
    // free-running clock
    always #2.5 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected status word: select picks latch or live level
    function automatic logic [31:0] expw();
        logic [31:0] w;
        w = 32'h0;
        for (int i = 0; i < 9; i++) w[POS[i]] = st[i] ? lt[i] : c[i];
        return w;
    endfunction
    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // write: each channel released when taken, then wait response
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [3:0] s);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk(s_axi_bresp, ISC_RESP_OKAY);
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // drive sources, let them settle, then step the model
    task automatic setp(input logic [8:0] s, input logic [7:0] f,
                        input logic [7:0] e);
        int n;
        @(posedge clk);
        link_pll_locked <= s[0];
        pattern_fail <= s[5:2];
        oscillator_align_trip_pair_a <= s[6];
        blanking_complete_pair_a <= s[7];
        power_threshold_error_pair_a <= s[8];
        lane_full <= f;
        lane_empty <= e;
        repeat (8) @(posedge clk);
        if ((f | e) != 8'h00) lerr = 1;
        n = (s & 9'h1fd) | (lerr << 1);
        lt = lt | (n & ~c & st);
        c = n;
    endtask
    // read the three status registers, one word each
    task automatic cmp();
        logic [31:0] w;
        w = expw();
        repeat (3) @(posedge clk);
        for (int b = 0; b < 3; b++) begin
            rd(12'(4 * (IX_STAT + b)));
            chk(rd_d, {24'h0, w[8*b+8 +: 8]});
            chk(rd_r, ISC_RESP_OKAY);
        end
        chk(irq_n, lt == 0);
    endtask
    // write-one-to-clear on flag register b, low byte
    task automatic clr(input int b, input logic [7:0] v);
        wr(12'(4 * (IX_STAT + b)), {24'h0, v}, 4'h1);
        for (int i = 0; i < 9; i++)
            if (POS[i] / 8 == b + 1 && v[POS[i] % 8]) lt = lt & ~(1 << i);
    endtask
    task automatic sel(input logic [8:0] v);
        wr(12'h040, {23'h0, v}, 4'h3);
        st = v;
        lt = lt & v;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        cmp();
        chk(link_enable, 1);
        // live mode across random source patterns
        for (int k = 0; k < 6; k++) begin
            setp(9'(rnd()), 8'h00, 8'h00);
            cmp();
        end
        // sticky mode: every source latches in turn
        sel(9'h1ff);
        setp(9'h000, 8'h00, 8'h00);
        for (int i = 0; i < 9; i++) begin
            setp(i == 1 ? 9'h000 : 9'(1 << i), 8'(i == 1), 8'h00);
            cmp();
        end
        setp(9'h000, 8'h00, 8'h00);
        cmp();
        clr(1, 8'h05);
        cmp();
        clr(0, 8'hff);
        clr(1, 8'hff);
        cmp();
        clr(2, 8'hff);
        cmp();
        // lane error is live, persistent, removed by link re-enable
        sel(9'h000);
        for (int k = 0; k < 3; k++) begin
            setp(9'h000, 8'(rnd()), 8'(rnd()));
            rd(12'(4 * IX_LANE));
            chk(rd_d, {24'h0, lane_full});
            rd(12'(4 * IX_LANE + 4));
            chk(rd_d, {24'h0, lane_empty});
            cmp();
        end
        setp(9'h000, 8'h00, 8'h00);
        cmp();
        wr(12'h044, 32'h0, 4'h1);
        chk(link_enable, 0);
        wr(12'h044, 32'h1, 4'h1);
        lerr = 0;
        c = c & ~2;
        chk(link_enable, 1);
        cmp();
        // unmapped address is refused with zero data
        rd(12'h100);
        chk(rd_r, ISC_RESP_SLVERR);
        chk(rd_d, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
